// ==== core/fcp_chan.sv ====
`timescale 1ns/1ps
module fcp_chan
   import fcp_pkg::*;
#(
   parameter int CW = CNT_W
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   // update enable: clock enable and run together
   input wire logic i_en,
   // working counter and compare value
   input wire logic [CW-1:0] i_cnt,
   input wire logic [CW-1:0] i_cmp,
   input wire logic i_inv,
   // channel output level
   output logic o_level
);

   typedef struct packed {
      logic level;
   } fcp_chan_state_t;

   fcp_chan_state_t s_q, s_d;
   logic raw;

   // uninverted level: high from period start until count drops below compare
   always_comb begin
      s_d = s_q;
      if (i_cmp == CW'(CMP_ALL_HIGH)) begin
         raw = 1'b1;
      end else if (i_cmp == CW'(CMP_ALL_LOW)) begin
         raw = 1'b0;
      end else begin
         raw = (i_cnt >= i_cmp);
      end
      // stopped outputs hold their last level, inversion included
      if (i_en) begin
         s_d.level = raw ^ i_inv;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         s_q <= '{level: RST_LEVEL};
      end else begin
         s_q <= s_d;
      end
   end

   assign o_level = s_q.level;

   property p_zero_high;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_en && i_cmp == CW'(CMP_ALL_HIGH)) |=> (o_level == !$past(i_inv));
   endproperty
   a_zero_high: assert property (p_zero_high) else $error("zero code not high");

   property p_ones_low;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_en && i_cmp == CW'(CMP_ALL_LOW)) |=> (o_level == $past(i_inv));
   endproperty
   a_ones_low: assert property (p_ones_low) else $error("all ones code not low");

   property p_below_low;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_en && i_cmp != CW'(CMP_ALL_HIGH) && i_cnt < i_cmp) |=> (o_level == $past(i_inv));
   endproperty
   a_below_low: assert property (p_below_low) else $error("output not low below compare");

   property p_above_high;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_en && i_cmp != CW'(CMP_ALL_LOW) && i_cnt >= i_cmp) |=> (o_level != $past(i_inv));
   endproperty
   a_above_high: assert property (p_above_high) else $error("output not high above compare");

endmodule

// ==== core/fcp_pkg.sv ====
package fcp_pkg;

   // widths of the counter, compare values and register bytes
   localparam int NCH = 4;
   localparam int CNT_W = 10;
   localparam int BYTE_W = 8;
   localparam int HI_W = CNT_W - BYTE_W;

   // register offsets as seen on the byte-wide register port
   localparam logic [7:0] ADR_PER_LO = 8'hd9;
   localparam logic [7:0] ADR_PER_HI = 8'hd1;
   localparam logic [7:0] ADR_CTRL = 8'hdc;
   localparam logic [7:0] ADR_BRAKE = 8'hdf;
   // compare holding bytes, element i belongs to channel i
   localparam logic [NCH-1:0][7:0] ADR_CMP_LO = {8'hde, 8'hdd, 8'hdb, 8'hda};
   localparam logic [NCH-1:0][7:0] ADR_CMP_HI = {8'hd6, 8'hd5, 8'hd3, 8'hd2};

   // main control byte layout
   localparam int CTRL_RUN_BIT = 7;
   localparam int CTRL_LOAD_BIT = 6;
   localparam int CTRL_FLAG_BIT = 5;
   localparam int CTRL_CLR_BIT = 4;
   localparam int CTRL_INV_LSB = 0;

   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [CNT_W-1:0] RST_WORD = 10'h000;
   localparam logic RST_LEVEL = 1'b1;

   // special compare codes
   localparam logic [CNT_W-1:0] CMP_ALL_HIGH = 10'h000;
   localparam logic [CNT_W-1:0] CMP_ALL_LOW = 10'h3ff;

   // prescaler default: one counter tick per system clock
   localparam int PRESCALE_DEF = 1;

endpackage

// ==== core/fcp_top.sv ====
// What this block does
// - ten-bit down counter reloads period at underflow
// - output high, low once count below compare
// - compare above reload value keeps output low
// - compare code zero keeps output high
// - compare code all ones keeps output low
// - channel three compare split low/high bytes
// - run bit starts and stops the counter
// - load copies buffers at underflow, then self-clears
// - without load, working values never change
// - underflow sets the polled flag
// - flag raises no interrupt
// - writing clear bit zeroes the counter
// - per-channel invert bits complement outputs
// - load while stopped never completes
// - rewriting run without load cancels transfer
// - clearing run freezes outputs
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module fcp_top
   import fcp_pkg::*;
#(
   parameter int PRESCALE = PRESCALE_DEF,
   parameter int PRESC_W = 4
) (
   // clock, reset, clock enable
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_clk_en,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic [BYTE_W-1:0] i_wr_data,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   output logic [BYTE_W-1:0] o_rd_data,
   // channel outputs
   output logic [NCH-1:0] o_pwm
);

   localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(PRESCALE - 1);
   localparam logic [PRESC_W-1:0] PRESC_ZERO = '0;
   localparam logic [HI_W-1:0] HI_ZERO = '0;
   localparam logic [BYTE_W-HI_W-1:0] PAD_ZERO = '0;

   typedef struct packed {
      logic run;
      logic load;
      logic flag;
      logic [NCH-1:0] inv;
      logic load_clr;
      logic [PRESC_W-1:0] presc;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] per_buf;
      logic [CNT_W-1:0] per_work;
      logic [NCH-1:0][CNT_W-1:0] cmp_buf;
      logic [NCH-1:0][CNT_W-1:0] cmp_work;
      logic [BYTE_W-1:0] brake;
      logic [BYTE_W-1:0] rd_data;
   } fcp_state_t;

   localparam fcp_state_t RST_STATE = '{
      run: 1'b0,
      load: 1'b0,
      flag: 1'b0,
      inv: '0,
      load_clr: 1'b0,
      presc: PRESC_ZERO,
      cnt: RST_WORD,
      per_buf: RST_WORD,
      per_work: RST_WORD,
      cmp_buf: '0,
      cmp_work: '0,
      brake: RST_BYTE,
      rd_data: RST_BYTE
   };

   fcp_state_t s_q, s_d;

   // decoded events of the current cycle
   logic tick;
   logic undf;
   logic xfer;
   logic ctrl_wr;
   logic clr_req;
   logic [CNT_W-1:0] reload_val;

   // one combinational pass: counter, transfer, register port, read mux
   always_comb begin
      s_d = s_q;
      s_d.rd_data = RST_BYTE; // read data valid for one cycle only

      // prescaled tick, only while running
      tick = s_q.run && (s_q.presc == PRESC_LAST);
      if (s_q.run) begin
         s_d.presc = tick ? PRESC_ZERO : s_q.presc + 1'b1;
      end

      // underflow when a tick finds the counter at zero
      undf = tick && (s_q.cnt == RST_WORD);
      // a stopped counter never underflows, so a stalled load waits forever
      xfer = undf && s_q.load;
      reload_val = s_q.load ? s_q.per_buf : s_q.per_work;
      if (tick) begin
         s_d.cnt = undf ? reload_val : s_q.cnt - 1'b1;
      end

      // working copies change only on a completed transfer
      if (xfer) begin
         s_d.per_work = s_q.per_buf;
         s_d.cmp_work = s_q.cmp_buf;
      end

      // load drops one clock after the transfer; a new write may re-set it
      s_d.load_clr = xfer;
      if (s_q.load_clr) begin
         s_d.load = 1'b0;
      end

      ctrl_wr = i_wr_en && (i_addr == ADR_CTRL);
      clr_req = ctrl_wr && i_wr_data[CTRL_CLR_BIT];

      // software writes; holding bytes never touch working copies
      if (i_wr_en) begin
         if (i_addr == ADR_PER_LO) begin
            s_d.per_buf[BYTE_W-1:0] = i_wr_data;
         end
         if (i_addr == ADR_PER_HI) begin
            s_d.per_buf[CNT_W-1:BYTE_W] = i_wr_data[HI_W-1:0];
         end
         for (int i = 0; i < NCH; i++) begin
            if (i_addr == ADR_CMP_LO[i]) begin
               s_d.cmp_buf[i][BYTE_W-1:0] = i_wr_data;
            end
            if (i_addr == ADR_CMP_HI[i]) begin
               s_d.cmp_buf[i][CNT_W-1:BYTE_W] = i_wr_data[HI_W-1:0];
            end
         end
         if (i_addr == ADR_BRAKE) begin
            s_d.brake = i_wr_data;
         end
      end

      // control write; run without load drops a pending transfer
      if (ctrl_wr) begin
         s_d.run = i_wr_data[CTRL_RUN_BIT];
         s_d.load = i_wr_data[CTRL_LOAD_BIT];
         s_d.flag = i_wr_data[CTRL_FLAG_BIT];
         s_d.inv = i_wr_data[CTRL_INV_LSB +: NCH];
      end
      if (clr_req) begin
         s_d.cnt = RST_WORD;
      end

      // flag set wins over a same-cycle software clear; polled only
      if (undf) begin
         s_d.flag = 1'b1;
      end

      // read mux; unmapped offsets and reserved bits read zero
      if (i_rd_en) begin
         if (i_addr == ADR_CTRL) begin
            s_d.rd_data = {s_q.run, s_q.load, s_q.flag, 1'b0, s_q.inv};
         end
         if (i_addr == ADR_PER_LO) begin
            s_d.rd_data = s_q.per_buf[BYTE_W-1:0];
         end
         if (i_addr == ADR_PER_HI) begin
            s_d.rd_data = {PAD_ZERO, s_q.per_buf[CNT_W-1:BYTE_W]};
         end
         if (i_addr == ADR_BRAKE) begin
            s_d.rd_data = s_q.brake;
         end
         for (int i = 0; i < NCH; i++) begin
            if (i_addr == ADR_CMP_LO[i]) begin
               s_d.rd_data = s_q.cmp_buf[i][BYTE_W-1:0];
            end
            if (i_addr == ADR_CMP_HI[i]) begin
               s_d.rd_data = {PAD_ZERO, s_q.cmp_buf[i][CNT_W-1:BYTE_W]};
            end
         end
      end
   end

   // low clock enable freezes everything, strobes included
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         s_q <= RST_STATE;
      end else if (i_clk_en) begin
         s_q <= s_d;
      end
   end

   assign o_rd_data = s_q.rd_data;

   // one output stage per channel, updated only while running
   generate
      for (genvar g = 0; g < NCH; g++) begin : g_chan
         fcp_chan #(
            .CW(CNT_W)
         ) u_chan (
            .i_sys_clk(i_sys_clk),
            .i_rstn(i_rstn),
            .i_en(i_clk_en && s_q.run),
            .i_cnt(s_q.cnt),
            .i_cmp(s_q.cmp_work[g]),
            .i_inv(s_q.inv[g]),
            .o_level(o_pwm[g])
         );
      end
   endgenerate

   // checks on counter, transfer and control behaviour

   property p_reload;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_clk_en && undf && !clr_req) |=> (s_q.cnt == $past(reload_val));
   endproperty
   a_reload: assert property (p_reload) else $error("counter not reloaded at underflow");

   property p_flag;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_clk_en && undf) |=> s_q.flag;
   endproperty
   a_flag: assert property (p_flag) else $error("underflow flag not set");

   property p_load_clear;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_clk_en && xfer) ##1 (i_clk_en && !ctrl_wr) |=> !s_q.load;
   endproperty
   a_load_clear: assert property (p_load_clear) else $error("load not cleared after transfer");

   property p_transfer;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_clk_en && xfer) |=> (s_q.per_work == $past(s_q.per_buf)) &&
         (s_q.cmp_work == $past(s_q.cmp_buf));
   endproperty
   a_transfer: assert property (p_transfer) else $error("buffers not copied on transfer");

   property p_hold_work;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      !s_q.load |=> $stable(s_q.per_work) && $stable(s_q.cmp_work);
   endproperty
   a_hold_work: assert property (p_hold_work) else $error("working values moved without load");

   property p_clear;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_clk_en && clr_req) |=> (s_q.cnt == RST_WORD);
   endproperty
   a_clear: assert property (p_clear) else $error("counter clear failed");

   property p_stalled_load;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      (!s_q.run && s_q.load && !ctrl_wr) |=> s_q.load && $stable(s_q.cmp_work);
   endproperty
   a_stalled_load: assert property (p_stalled_load) else $error("load completed while stopped");

   property p_freeze;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      !s_q.run |=> $stable(o_pwm);
   endproperty
   a_freeze: assert property (p_freeze) else $error("outputs moved while stopped");

   property p_stopped_count;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      (!s_q.run && !(i_clk_en && clr_req)) |=> $stable(s_q.cnt) && !$rose(s_q.flag & ~ctrl_wr);
   endproperty
   a_stopped_count: assert property (p_stopped_count) else $error("counter moved while stopped");

   // read port: data stands one cycle only, reserved high bits read zero
   property p_rd_idle;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_clk_en && !i_rd_en) |=> (o_rd_data == RST_BYTE);
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");

   property p_rd_hi_reserved;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_clk_en && i_rd_en && i_addr == ADR_CMP_HI[NCH-1]) |=> (o_rd_data[BYTE_W-1:HI_W] == '0);
   endproperty
   a_rd_hi_reserved: assert property (p_rd_hi_reserved) else $error("reserved bits set");

   // holding byte write lands in the buffer only
   property p_buf_write;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_clk_en && i_wr_en && i_addr == ADR_CMP_LO[NCH-1]) |=>
         (s_q.cmp_buf[NCH-1][BYTE_W-1:0] == $past(i_wr_data));
   endproperty
   a_buf_write: assert property (p_buf_write) else $error("compare low byte not stored");

   // control write without load drops any pending transfer
   property p_cancel;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_clk_en && ctrl_wr && !i_wr_data[CTRL_LOAD_BIT]) |=> !s_q.load;
   endproperty
   a_cancel: assert property (p_cancel) else $error("pending load not cancelled");

   // run bit follows the control write in both directions
   property p_run_start;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_clk_en && ctrl_wr && i_wr_data[CTRL_RUN_BIT]) |=> s_q.run;
   endproperty
   a_run_start: assert property (p_run_start) else $error("run not started");

   property p_run_stop;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_clk_en && ctrl_wr && !i_wr_data[CTRL_RUN_BIT]) |=> !s_q.run;
   endproperty
   a_run_stop: assert property (p_run_stop) else $error("run not stopped");

   // flag only moves on underflow or a control write; never self-clears
   property p_flag_hold;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_clk_en && !undf && !ctrl_wr) |=> (s_q.flag == $past(s_q.flag));
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag changed by itself");

   // invert bits taken straight from the control write
   property p_inv_write;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_clk_en && ctrl_wr) |=> (s_q.inv == $past(i_wr_data[CTRL_INV_LSB +: NCH]));
   endproperty
   a_inv_write: assert property (p_inv_write) else $error("invert bits not written");

   // ordinary tick counts down by one
   property p_count_down;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_clk_en && tick && !undf && !clr_req) |=> (s_q.cnt == $past(s_q.cnt) - 1'b1);
   endproperty
   a_count_down: assert property (p_count_down) else $error("counter did not decrement");

   // pending load survives until the edge after its transfer
   property p_load_hold;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_clk_en && s_q.load && !s_q.load_clr && !ctrl_wr) |=> s_q.load;
   endproperty
   a_load_hold: assert property (p_load_hold) else $error("load dropped early");

   // a low clock enable freezes every bit of state
   property p_clk_en_freeze;
      @(posedge i_sys_clk) disable iff (!i_rstn)
      !i_clk_en |=> $stable(s_q);
   endproperty
   a_clk_en_freeze: assert property (p_clk_en_freeze) else $error("state moved while disabled");

endmodule

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
   import fcp_pkg::*;

   // design inputs, all given a value at time zero
   logic i_sys_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic i_clk_en = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic [BYTE_W-1:0] i_wr_data = 8'h00;
   logic i_wr_en = 1'b0;
   logic i_rd_en = 1'b0;
   logic [BYTE_W-1:0] o_rd_data;
   logic [NCH-1:0] o_pwm;
   int failures = 0;
   int check_count = 0;
   logic [7:0] rdv;
   logic [NCH-1:0] snap;
   int hi_cnt [NCH];
   logic [CNT_W-1:0] cmpv [NCH] = '{10'h000, 10'h3ff, 10'h005, 10'h002};

   fcp_top #(.PRESCALE(1), .PRESC_W(4)) i_fcp_top (
      .i_sys_clk(i_sys_clk),
      .i_rstn(i_rstn),
      .i_clk_en(i_clk_en),
      .i_addr(i_addr),
      .i_wr_data(i_wr_data),
      .i_wr_en(i_wr_en),
      .i_rd_en(i_rd_en),
      .o_rd_data(o_rd_data),
      .o_pwm(o_pwm)
   );

   // 20 mhz system clock
   initial begin
      forever #25 i_sys_clk = ~i_sys_clk;
   end

   task automatic mism(input string m);
      failures++;
      $display("unexpected at %0t: %s", $time, m);
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // one-cycle write strobe; lowered at the next edge, so calls never collide
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_wr_data <= d;
      i_wr_en <= 1'b1;
      @(posedge i_sys_clk);
      i_wr_en <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd_en <= 1'b1;
      @(posedge i_sys_clk);
      i_rd_en <= 1'b0;
      #1;
      d = o_rd_data;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         mism($sformatf("%s got %h want %h", m, got, exp));
      end
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
      rd(a, rdv);
      chk8(rdv, exp, $sformatf("read %h", a));
   endtask

   // high cycles per channel over 8 cycles; any window of whole periods
   task automatic chk_counts(input int e [NCH]);
      for (int c = 0; c < NCH; c++) begin
         hi_cnt[c] = 0;
      end
      repeat (8) begin
         @(negedge i_sys_clk);
         for (int c = 0; c < NCH; c++) begin
            if (o_pwm[c] === 1'b1) begin
               hi_cnt[c]++;
            end
         end
      end
      for (int c = 0; c < NCH; c++) begin
         check_count++;
         if (hi_cnt[c] != e[c]) begin
            mism($sformatf("channel %0d high %0d want %0d", c, hi_cnt[c], e[c]));
         end
      end
   endtask

   // poll until hardware drops the load request, bounded
   task automatic poll_load(input int lim);
      int n;
      n = 0;
      rdv = 8'hff;
      while (rdv[CTRL_LOAD_BIT] !== 1'b0 && n < lim) begin
         rd(ADR_CTRL, rdv);
         n++;
      end
      check_count++;
      if (rdv[CTRL_LOAD_BIT] !== 1'b0) begin
         mism("load request never cleared");
      end
   endtask

   // watchdog well above the roughly 2200 cycles the tests need
   initial begin
      repeat (20000) @(posedge i_sys_clk);
      mism("watchdog expired");
      final_report();
   end

   initial begin
      repeat (10) @(posedge i_sys_clk);
      i_rstn <= 1'b1;
      chk_rd(ADR_CTRL, 8'h00);
      chk_rd(ADR_CMP_LO[3], 8'h00);
      chk8({4'h0, o_pwm}, 8'h0f, "outputs after reset");
      wr(ADR_CMP_HI[3], 8'hff);
      chk_rd(ADR_CMP_HI[3], 8'h03);
      wr(ADR_CMP_LO[3], 8'ha5);
      chk_rd(ADR_CMP_LO[3], 8'ha5);
      chk_rd(8'he0, 8'h00);
      // load without run must stay pending; clear bit reads back 0
      wr(ADR_CTRL, 8'h50);
      repeat (10) @(posedge i_sys_clk);
      chk_rd(ADR_CTRL, 8'h40);
      $display("test registers done");

      // period 3: four ticks; codes 000, 3ff, above period, mid value
      wr(ADR_PER_LO, 8'h03);
      wr(ADR_PER_HI, 8'h00);
      for (int c = 0; c < NCH; c++) begin
         wr(ADR_CMP_LO[c], cmpv[c][7:0]);
         wr(ADR_CMP_HI[c], {6'h00, cmpv[c][9:8]});
      end
      wr(ADR_CTRL, 8'hc0);
      poll_load(20);
      chk_rd(ADR_CTRL, 8'ha0);
      chk_counts('{8, 0, 0, 4});
      wr(ADR_CTRL, 8'hcf);
      poll_load(20);
      chk_counts('{0, 8, 8, 4});
      // low clock enable: the edge after the drop is already frozen
      @(posedge i_sys_clk);
      i_clk_en <= 1'b0;
      @(posedge i_sys_clk);
      snap = o_pwm;
      repeat (20) @(posedge i_sys_clk);
      chk8({4'h0, o_pwm}, {4'h0, snap}, "outputs with clock enable low");
      i_clk_en <= 1'b1;
      $display("test waveform done");

      // long period so the cancel lands well before the next underflow
      wr(ADR_PER_LO, 8'hfe);
      wr(ADR_PER_HI, 8'h03);
      wr(ADR_CTRL, 8'hc0);
      poll_load(20);
      wr(ADR_CMP_LO[0], 8'hff);
      wr(ADR_CMP_HI[0], 8'h03);
      wr(ADR_CTRL, 8'hc0);
      wr(ADR_CTRL, 8'h80);
      repeat (1100) @(posedge i_sys_clk);
      chk_rd(ADR_CTRL, 8'ha0);
      chk8({7'h00, o_pwm[0]}, 8'h01, "cancelled compare");
      $display("test cancel done");

      // known halt: special codes, load with run, poll, then stop
      wr(ADR_CMP_LO[1], 8'h00);
      wr(ADR_CMP_HI[1], 8'h00);
      wr(ADR_CTRL, 8'hc0);
      poll_load(800);
      wr(ADR_CTRL, 8'h00);
      repeat (2) @(posedge i_sys_clk);
      snap = o_pwm;
      repeat (50) @(posedge i_sys_clk);
      chk8({4'h0, o_pwm}, {4'h0, snap}, "frozen outputs");
      chk8({6'h00, o_pwm[1:0]}, 8'h02, "halt levels");
      chk_rd(ADR_CTRL, 8'h00);
      // cleared counter underflows at the first tick after run
      wr(ADR_CTRL, 8'h10);
      wr(ADR_CTRL, 8'h80);
      chk_rd(ADR_CTRL, 8'ha0);
      $display("test halt done");
      final_report();
   end
endmodule
